// *** olk_params.svh ***
/*
  Named constants of the fuse-zone access policy block: register offsets,
  field positions, lock codes and reset values.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef OLK_PARAMS_SVH
`define OLK_PARAMS_SVH

// ==========================================================
// Sizes
`define OLK_WORD_W 32
`define OLK_OTP_WORDS 16
`define OLK_WADDR_W 4
`define OLK_KEY_W 256
`define OLK_SLOT_W 4
`define OLK_AVS_AW 6

// ==========================================================
// Lock and mode codes
`define OLK_UNLOCKED 8'h55
`define OLK_LOCKED 8'h00
`define OLK_MODE_RST 8'h00
`define OLK_LEGACY_MIN_WORD 4'h2
`define OLK_BURST_LEFT 3'h7

// ==========================================================
// Register byte offsets
`define OLK_A_LOCK 6'h00
`define OLK_A_MODE 6'h04
`define OLK_A_FIXED 6'h08
`define OLK_A_OTPCMD 6'h0C
`define OLK_A_WDATA 6'h10
`define OLK_A_RDATA 6'h14
`define OLK_A_STAT 6'h18
`define OLK_A_DZCMD 6'h1C
`define OLK_A_KEYCMD 6'h20
`define OLK_A_KEYDAT 6'h24

// ==========================================================
// Field positions
`define OLK_B_CFG 0
`define OLK_B_DAT 1
`define OLK_F_WORD 3:0
`define OLK_F_ALIGN 2:0
`define OLK_B_WR 8
`define OLK_B_LEN32 9
`define OLK_F_OP 1:0
`define OLK_B_KERR 4
`define OLK_B_KCRC 5
`define OLK_B_KSRC 6
`define OLK_F_KSLOT 11:8
`define OLK_B_KVONLY 12
`define OLK_F_BYTE 7:0

// ==========================================================
// Ephemeral key command codes
`define OLK_OP_NONCE 2'h1
`define OLK_OP_DIGEST 2'h2
`define OLK_OP_OTHER 2'h3

`endif

// *** olk_pkg.sv ***
/*
  Types of the fuse-zone access policy block: state enum and state structs.
  Assumes olk_params.svh is on the include path.
*/
`include "olk_params.svh"

package olk_pkg;

  // ==========================================================
  // Policy engine state
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_RMW} olk_state_t;

  typedef struct packed {
    olk_state_t state;
    logic [7:0] cfg_lock;
    logic [7:0] dat_lock;
    logic [7:0] mode;
    logic [`OLK_WADDR_W-1:0] word;
    logic [2:0] burst;
    logic [`OLK_WORD_W-1:0] wdata;
    logic [`OLK_WORD_W-1:0] rdata;
    logic [`OLK_WORD_W-1:0] rdd;
    logic err;
    logic done;
    logic rd_ack;
  } olk_top_st_t;

  // ==========================================================
  // Fuse word store
  typedef struct packed {
    logic [`OLK_OTP_WORDS-1:0][`OLK_WORD_W-1:0] word;
    logic [`OLK_WORD_W-1:0] rdata;
  } olk_mem_st_t;

  // ==========================================================
  // Ephemeral key register
  typedef struct packed {
    logic [`OLK_KEY_W-1:0] value;
    logic [`OLK_SLOT_W-1:0] slot;
    logic src;
    logic derived;
    logic restricted;
    logic valid;
  } olk_key_st_t;

endpackage

// *** olk_ifs.sv ***
/*
  Interfaces between the policy engine, the fuse word store and the
  ephemeral key register.
  Assumes all parties share one clock.
*/
`timescale 1ns/10ps
`include "olk_params.svh"

// ==========================================================
// Fuse word store port
interface olk_mem_if;
  logic rd_en;
  logic wr_en;
  logic [`OLK_WADDR_W-1:0] addr;
  logic [`OLK_WORD_W-1:0] wdata;
  logic [`OLK_WORD_W-1:0] rdata;
  modport ctl (output rd_en, wr_en, addr, wdata, input rdata);
  modport mem (input rd_en, wr_en, addr, wdata, output rdata);
endinterface

// ==========================================================
// Ephemeral key port
interface olk_key_if;
  logic cmd_valid;
  logic [1:0] cmd_op;
  logic cmd_err;
  logic cmd_crc;
  logic cmd_src;
  logic cmd_vonly;
  logic [`OLK_SLOT_W-1:0] cmd_slot;
  logic data_valid;
  logic [`OLK_WORD_W-1:0] data;
  logic wipe;
  logic valid;
  logic src;
  logic derived;
  logic restricted;
  logic [`OLK_SLOT_W-1:0] slot;
  modport ctl (output cmd_valid, cmd_op, cmd_err, cmd_crc, cmd_src, cmd_vonly, cmd_slot,
    data_valid, data, wipe, input valid, src, derived, restricted, slot);
  modport key (input cmd_valid, cmd_op, cmd_err, cmd_crc, cmd_src, cmd_vonly, cmd_slot,
    data_valid, data, wipe, output valid, src, derived, restricted, slot);
endinterface

// *** olk_fuse_mem.sv ***
/*
  Sixteen-word fuse store with registered read data.
  Assumes one access per cycle from the policy engine.
*/
`timescale 1ns/10ps
`include "olk_params.svh"

module olk_fuse_mem
  import olk_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Store port
  olk_mem_if.mem m
);

  olk_mem_st_t st_r;
  olk_mem_st_t st_nxt;

  // ==========================================================
  // Access
  always_comb begin
    st_nxt = st_r;
    if (m.rd_en) begin
      st_nxt.rdata = st_r.word[m.addr];
    end
    if (m.wr_en) begin
      st_nxt.word[m.addr] = m.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '{word: '1, rdata: '0}; // [R9]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign m.rdata = st_r.rdata;

endmodule

// *** olk_eph_key.sv ***
/*
  Ephemeral key register with its tag bits and validity tracking.
  Assumes commands arrive as one-cycle pulses from the policy engine.
*/
`timescale 1ns/10ps
`include "olk_params.svh"

module olk_eph_key
  import olk_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Command port
  olk_key_if.key k
);

  olk_key_st_t st_r;
  olk_key_st_t st_nxt;

  // ==========================================================
  // Update
  always_comb begin
    st_nxt = st_r;
    if (k.data_valid) begin
      st_nxt.value = {st_r.value[`OLK_KEY_W-`OLK_WORD_W-1:0], k.data}; // [R16]
    end
    if (k.cmd_valid && !k.cmd_crc) begin // [R21]
      case (k.cmd_op)
        `OLK_OP_NONCE: begin
          st_nxt.valid = !k.cmd_err; // [R22]
          st_nxt.src = k.cmd_src; // [R18]
          st_nxt.derived = 1'b0; // [R22]
          st_nxt.restricted = 1'b0;
          st_nxt.slot = '0;
        end
        `OLK_OP_DIGEST: begin
          st_nxt.valid = !k.cmd_err; // [R22]
          st_nxt.derived = 1'b1; // [R19]
          st_nxt.restricted = k.cmd_vonly; // [R19]
          st_nxt.slot = k.cmd_slot;
        end
        default: begin
          st_nxt.valid = 1'b0; // [R21]
        end
      endcase
    end
    if (k.wipe) begin
      st_nxt = '0; // [R15] [R20]
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0; // [R20]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign k.valid = st_r.valid;
  assign k.src = st_r.src;
  assign k.derived = st_r.derived;
  assign k.restricted = st_r.restricted;
  assign k.slot = st_r.slot;

  // ==========================================================
  // Checks
  wipe_clears_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R15] [R20]
    k.wipe |=> !st_r.valid && st_r.value == '0)
    else $error("key survived a wipe");
  other_clears_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R21]
    k.cmd_valid && !k.cmd_crc && k.cmd_op == `OLK_OP_OTHER |=> !st_r.valid)
    else $error("key valid after other command");
  crc_keeps_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R21]
    k.cmd_valid && k.cmd_crc && !k.wipe |=> st_r.valid == $past(st_r.valid))
    else $error("crc reject changed key valid");
  nonce_src_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R18]
    k.cmd_valid && !k.cmd_crc && !k.wipe && k.cmd_op == `OLK_OP_NONCE
      |=> st_r.src == $past(k.cmd_src) && !st_r.derived)
    else $error("nonce tags wrong");
  digest_tag_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R19] [R22]
    k.cmd_valid && !k.cmd_crc && !k.wipe && k.cmd_op == `OLK_OP_DIGEST
      |=> st_r.derived && st_r.valid == !$past(k.cmd_err)
      && st_r.restricted == $past(k.cmd_vonly))
    else $error("digest tags wrong");

endmodule

// *** olk_policy_top.sv ***
/*
  Access policy for the fuse zone and the data zone, lock bytes, policy
  mode byte, and the ephemeral key register, behind an Avalon-MM slave.
  Assumes the slot configuration decoder supplies the per-slot read and
  write permissions, and power management supplies one wipe pulse.
*/
// How it works
// [R1] - 64-byte fuse zone closed while config open
// [R2] - Before data lock: writes only, no reads
// [R3] - Read-only mode: writes error, contents unchanged
// [R4] - Read-only mode: 4- and 32-byte reads allowed
// [R5] - Consumption mode stores data AND current word
// [R6] - Legacy mode: words 0,1 unreadable, rest readable
// [R7] - Legacy mode: 32-byte read returns error
// [R8] - Legacy mode: all fuse writes refused
// [R9] - Sixteen words, all ones as delivered
// [R10] - Lock bytes change only by lock, forever
// [R11] - Zone access before config lock errors
// [R12] - Config unlocked only at 0x55; then frozen
// [R13] - Fixed config word never writable
// [R14] - Data zone: write-only until locked, then slots
// [R15] - Sleep or power loss wipes scratch key
// [R16] - Key holds value, slot, three flags, valid
// [R17] - Key value never returned to host
// [R18] - Source flag: 0 random, 1 seed only
// [R19] - Restricted and derived flags from digest generation
// [R20] - Power events clear valid; idle keeps it
// [R21] - Other commands clear valid, except CRC reject
// [R22] - Nonce/digest errors clear valid; each overwrites
// [R23] - Policy mode codes come from inputs
`timescale 1ns/10ps
`include "olk_params.svh"

module olk_policy_top
  import olk_pkg::*;
#(
  // Arbitrary value for the fixed identity word
  parameter logic [`OLK_WORD_W-1:0] FIXED_ID = 32'h0000_0A5A
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [`OLK_AVS_AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [`OLK_WORD_W-1:0] avs_writedata_in,
  output logic [`OLK_WORD_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Policy mode decode
  input wire logic [7:0] mode_ro_code_in,
  input wire logic [7:0] mode_cons_code_in,
  input wire logic [7:0] mode_legacy_code_in,
  // Slot permissions after data lock
  input wire logic slot_read_ok_in,
  input wire logic slot_write_ok_in,
  // Power-up, sleep, brown-out, watchdog, tamper
  input wire logic power_wipe_in
);

  localparam olk_top_st_t TOP_RST = '{
    state: ST_IDLE,
    cfg_lock: `OLK_UNLOCKED,
    dat_lock: `OLK_UNLOCKED,
    mode: `OLK_MODE_RST,
    default: '0
  };

  olk_top_st_t st_r;
  olk_top_st_t st_nxt;
  olk_mem_if mif ();
  olk_key_if kif ();

  logic busy;
  logic rd_go;
  logic wr_go;
  logic cfg_open;
  logic dat_open;
  logic wr_bit;
  logic len32;
  logic otp_cmd;
  logic dz_cmd;
  logic [`OLK_WADDR_W-1:0] cmd_word;

  // ==========================================================
  // Fuse zone permission
  function automatic logic otp_ok(
    input logic wr,
    input logic l32,
    input logic [`OLK_WADDR_W-1:0] word,
    input logic [7:0] cfg,
    input logic [7:0] dat,
    input logic [7:0] mode,
    input logic [7:0] ro,
    input logic [7:0] cons,
    input logic [7:0] leg
  );
    logic ok;
    ok = 1'b0;
    if (l32 && (wr || word[`OLK_F_ALIGN] != 3'h0)) begin
      ok = 1'b0;
    end else if (cfg == `OLK_UNLOCKED) begin
      ok = 1'b0; // [R1] [R11] [R12]
    end else if (dat == `OLK_UNLOCKED) begin
      ok = wr; // [R2]
    end else if (mode == ro) begin
      ok = !wr; // [R3] [R4]
    end else if (mode == cons) begin
      ok = 1'b1; // [R5]
    end else if (mode == leg) begin
      ok = !wr && !l32 && word >= `OLK_LEGACY_MIN_WORD; // [R6] [R7] [R8]
    end
    return ok;
  endfunction

  // ==========================================================
  // Bus handshake
  assign busy = st_r.state != ST_IDLE;
  assign rd_go = avs_read_in && !st_r.rd_ack && !busy;
  assign wr_go = avs_write_in && !busy;
  assign avs_waitrequest_out = (avs_read_in && !st_r.rd_ack) || (avs_write_in && busy);
  assign avs_readdata_out = st_r.rdd;

  assign cfg_open = st_r.cfg_lock == `OLK_UNLOCKED; // [R12]
  assign dat_open = st_r.dat_lock == `OLK_UNLOCKED; // [R14]
  assign wr_bit = avs_writedata_in[`OLK_B_WR];
  assign len32 = avs_writedata_in[`OLK_B_LEN32];
  assign cmd_word = avs_writedata_in[`OLK_F_WORD];
  assign otp_cmd = wr_go && avs_address_in == `OLK_A_OTPCMD;
  assign dz_cmd = wr_go && avs_address_in == `OLK_A_DZCMD;

  // ==========================================================
  // Next state
  always_comb begin
    logic ok;
    ok = 1'b0;
    st_nxt = st_r;
    st_nxt.rd_ack = rd_go;
    mif.rd_en = 1'b0;
    mif.wr_en = 1'b0;
    mif.addr = st_r.word;
    mif.wdata = st_r.wdata;
    kif.cmd_valid = 1'b0;
    kif.cmd_op = `OLK_OP_OTHER;
    kif.cmd_err = avs_writedata_in[`OLK_B_KERR];
    kif.cmd_crc = 1'b0;
    kif.cmd_src = avs_writedata_in[`OLK_B_KSRC];
    kif.cmd_vonly = avs_writedata_in[`OLK_B_KVONLY];
    kif.cmd_slot = avs_writedata_in[`OLK_F_KSLOT];
    kif.data_valid = 1'b0;
    kif.data = avs_writedata_in;
    kif.wipe = power_wipe_in; // [R15] [R20]
    if (rd_go) begin
      case (avs_address_in)
        `OLK_A_LOCK: begin
          st_nxt.rdd = {16'h0000, st_r.dat_lock, st_r.cfg_lock};
        end
        `OLK_A_MODE: begin
          st_nxt.rdd = {24'h000000, st_r.mode}; // [R12]
        end
        `OLK_A_FIXED: begin
          st_nxt.rdd = FIXED_ID; // [R13]
        end
        `OLK_A_RDATA: begin
          st_nxt.rdd = st_r.rdata;
          if (st_r.burst != 3'h0) begin
            st_nxt.word = st_r.word + 4'h1; // [R4]
            st_nxt.burst = st_r.burst - 3'h1;
            st_nxt.done = 1'b0;
            mif.rd_en = 1'b1;
            mif.addr = st_r.word + 4'h1;
            st_nxt.state = ST_RD;
          end
        end
        `OLK_A_STAT: begin
          st_nxt.rdd = {20'h00000, kif.slot, 2'b00, kif.restricted, kif.derived,
            kif.src, kif.valid, st_r.done, st_r.err}; // [R16] [R17]
        end
        default: begin
          st_nxt.rdd = 32'h00000000;
        end
      endcase
    end
    if (wr_go) begin
      case (avs_address_in)
        `OLK_A_LOCK: begin
          kif.cmd_valid = 1'b1; // [R21]
          st_nxt.done = 1'b1;
          st_nxt.err = 1'b0;
          if (avs_writedata_in[`OLK_B_CFG] && cfg_open) begin
            st_nxt.cfg_lock = `OLK_LOCKED; // [R10]
          end
          if (avs_writedata_in[`OLK_B_DAT] && !cfg_open && dat_open) begin
            st_nxt.dat_lock = `OLK_LOCKED; // [R10]
          end
        end
        `OLK_A_MODE: begin
          kif.cmd_valid = 1'b1;
          st_nxt.done = 1'b1;
          st_nxt.err = !cfg_open; // [R12]
          if (cfg_open) begin
            st_nxt.mode = avs_writedata_in[`OLK_F_BYTE];
          end
        end
        `OLK_A_FIXED: begin
          kif.cmd_valid = 1'b1;
          st_nxt.done = 1'b1;
          st_nxt.err = 1'b1; // [R13]
        end
        `OLK_A_OTPCMD: begin
          kif.cmd_valid = 1'b1; // [R21]
          ok = otp_ok(wr_bit, len32, cmd_word, st_r.cfg_lock, st_r.dat_lock, st_r.mode,
            mode_ro_code_in, mode_cons_code_in, mode_legacy_code_in); // [R23]
          st_nxt.word = cmd_word;
          st_nxt.err = !ok;
          st_nxt.done = !ok;
          st_nxt.burst = (ok && len32) ? `OLK_BURST_LEFT : 3'h0; // [R4]
          if (ok) begin
            mif.rd_en = 1'b1;
            mif.addr = cmd_word;
            st_nxt.state = wr_bit ? ST_RMW : ST_RD;
          end
        end
        `OLK_A_WDATA: begin
          st_nxt.wdata = avs_writedata_in;
        end
        `OLK_A_DZCMD: begin
          kif.cmd_valid = 1'b1;
          if (cfg_open) begin
            ok = 1'b0; // [R11]
          end else if (dat_open) begin
            ok = wr_bit; // [R14]
          end else begin
            ok = wr_bit ? slot_write_ok_in : slot_read_ok_in; // [R14]
          end
          st_nxt.err = !ok;
          st_nxt.done = 1'b1;
        end
        `OLK_A_KEYCMD: begin
          kif.cmd_valid = 1'b1;
          kif.cmd_op = avs_writedata_in[`OLK_F_OP];
          kif.cmd_crc = avs_writedata_in[`OLK_B_KCRC]; // [R21]
          st_nxt.done = 1'b1;
          st_nxt.err = avs_writedata_in[`OLK_B_KERR];
        end
        `OLK_A_KEYDAT: begin
          kif.data_valid = 1'b1; // [R17]
        end
        default: begin
          st_nxt.err = st_r.err;
        end
      endcase
    end
    case (st_r.state)
      ST_RD: begin
        st_nxt.rdata = mif.rdata;
        st_nxt.done = 1'b1;
        st_nxt.state = ST_IDLE;
      end
      ST_RMW: begin
        mif.wr_en = 1'b1;
        if (!dat_open && st_r.mode == mode_cons_code_in) begin
          mif.wdata = st_r.wdata & mif.rdata; // [R5]
        end
        st_nxt.done = 1'b1;
        st_nxt.state = ST_IDLE;
      end
      default: begin
        st_nxt.state = st_nxt.state;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Sub-blocks
  olk_fuse_mem u_mem (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .m(mif.mem)
  );

  olk_eph_key u_key (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .k(kif.key)
  );

  // ==========================================================
  // Checks
  cfg_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R1] [R11]
    otp_cmd && cfg_open |=> st_r.err && st_r.done && st_r.state == ST_IDLE)
    else $error("fuse access allowed before config lock");
  early_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R2]
    otp_cmd && !wr_bit && !cfg_open && dat_open |=> st_r.err && !mif.wr_en)
    else $error("fuse read allowed before data lock");
  early_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R2]
    otp_cmd && wr_bit && !len32 && !cfg_open && dat_open
      |=> mif.wr_en && mif.wdata == st_r.wdata ##1 st_r.done && !st_r.err)
    else $error("fuse write refused before data lock");
  ro_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R3]
    otp_cmd && wr_bit && !dat_open && st_r.mode == mode_ro_code_in
      && st_r.mode != mode_cons_code_in |=> st_r.err && !mif.wr_en [*2])
    else $error("read-only fuse word written");
  ro_read_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R4]
    otp_cmd && !wr_bit && !len32 && !cfg_open && !dat_open
      && st_r.mode == mode_ro_code_in |=> st_r.state == ST_RD ##1 st_r.done && !st_r.err)
    else $error("read-only fuse read refused");
  cons_and_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R5]
    mif.wr_en && !dat_open && st_r.mode == mode_cons_code_in
      |-> mif.wdata == (st_r.wdata & mif.rdata))
    else $error("consumption write set a bit");
  legacy_rd_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R6] [R7]
    otp_cmd && !wr_bit && !cfg_open && !dat_open && st_r.mode == mode_legacy_code_in
      && st_r.mode != mode_ro_code_in && st_r.mode != mode_cons_code_in
      && (len32 || cmd_word < `OLK_LEGACY_MIN_WORD) |=> st_r.err)
    else $error("legacy read restriction missed");
  legacy_wr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R8]
    otp_cmd && wr_bit && !cfg_open && !dat_open && st_r.mode == mode_legacy_code_in
      && st_r.mode != mode_cons_code_in |=> st_r.err && !mif.wr_en)
    else $error("legacy fuse write allowed");
  lock_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R10]
    !cfg_open |=> st_r.cfg_lock == $past(st_r.cfg_lock))
    else $error("config lock undone");
  data_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R10]
    !dat_open |=> st_r.dat_lock == $past(st_r.dat_lock))
    else $error("data lock undone");
  mode_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R12]
    !cfg_open |=> $stable(st_r.mode))
    else $error("config byte changed after lock");
  fixed_wr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R13]
    wr_go && avs_address_in == `OLK_A_FIXED |=> st_r.err && st_r.done)
    else $error("fixed word write not refused");
  dz_open_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // [R14]
    dz_cmd && !cfg_open && dat_open |=> st_r.err == !$past(wr_bit))
    else $error("data zone open-state access wrong");

endmodule

// *** olk_host.sv ***
/*
  Host model: Avalon-MM master that issues register accesses to the block.
  Assumes one clock shared with the block; the bench calls task xfer.
*/
`timescale 1ns/10ps
`include "olk_params.svh"

module olk_host (
  // Clock
  input wire logic clk_in,
  // Avalon-MM master
  output logic [`OLK_AVS_AW-1:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [`OLK_WORD_W-1:0] writedata_out,
  input wire logic [`OLK_WORD_W-1:0] readdata_in,
  input wire logic waitrequest_in
);
  // ==========================================================
  // Bus cycle
  initial begin
    address_out <= '0;
    read_out <= 1'b0;
    write_out <= 1'b0;
    writedata_out <= '0;
  end

  task automatic xfer(input logic wr, input logic [`OLK_AVS_AW-1:0] a,
    input logic [`OLK_WORD_W-1:0] d, output logic [`OLK_WORD_W-1:0] q);
    @(posedge clk_in);
    address_out <= a;
    writedata_out <= d;
    write_out <= wr;
    read_out <= !wr;
    @(posedge clk_in);
    while (waitrequest_in) begin
      @(posedge clk_in);
    end
    q = readdata_in;
    write_out <= 1'b0;
    read_out <= 1'b0;
    address_out <= ~a;
    writedata_out <= ~d;
  endtask
endmodule

// *** olk_policy_top_tb.sv ***
/*
  Bench of the fuse-zone policy block: scenarios per task, host model drives
  the bus. Assumes the as-delivered state after reset.
*/
`timescale 1ns/10ps
`include "olk_params.svh"

module olk_policy_top_tb;
  import olk_pkg::*;
  logic clk_in, sys_rst_in, rd_o, wr_o, wait_i, pw, srd, swr;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  logic [7:0] ro, cons, leg;
  int fails, tests_run;

  olk_host host (.clk_in(clk_in), .address_out(adr), .read_out(rd_o), .write_out(wr_o),
    .writedata_out(wd), .readdata_in(rdat), .waitrequest_in(wait_i));
  olk_policy_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd_o), .avs_write_in(wr_o), .avs_writedata_in(wd),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_i), .mode_ro_code_in(ro),
    .mode_cons_code_in(cons), .mode_legacy_code_in(leg), .slot_read_ok_in(srd),
    .slot_write_ok_in(swr), .power_wipe_in(pw));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q & m, exp);
  endtask
  task automatic fuse(input logic [31:0] cmd, input logic [31:0] d, input logic err);
    wr(`OLK_A_WDATA, d);
    wr(`OLK_A_OTPCMD, cmd);
    q = 32'h0;
    for (int i = 0; i < 10 && !q[1]; i++) host.xfer(1'b0, `OLK_A_STAT, 32'h0, q);
    chk(q & 32'h3, {30'h0, 1'b1, err});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_open();
    rd(`OLK_A_LOCK, 32'h5555);
    rd(`OLK_A_MODE, 32'h0);
    rd(`OLK_A_FIXED, 32'h0A5A);
    wr(`OLK_A_FIXED, 32'h0);
    rd(`OLK_A_STAT, 32'h3);
    fuse(32'h3, 32'h0, 1'b1);
    wr(`OLK_A_DZCMD, 32'h100);
    rd(`OLK_A_STAT, 32'h3);
    wr(`OLK_A_MODE, 32'h2);
    wr(`OLK_A_LOCK, 32'h1);
    rd(`OLK_A_LOCK, 32'h5500);
    wr(`OLK_A_MODE, 32'h3);
    rd(`OLK_A_STAT, 32'h3);
    rd(`OLK_A_MODE, 32'h2);
    $display("test open done");
  endtask
  task automatic t_unlocked();
    fuse(32'h103, 32'h0F0F_FFFF, 1'b0);
    fuse(32'h3, 32'h0, 1'b1);
    wr(`OLK_A_DZCMD, 32'h100);
    rd(`OLK_A_STAT, 32'h2);
    wr(`OLK_A_DZCMD, 32'h0);
    rd(`OLK_A_STAT, 32'h3);
    wr(`OLK_A_LOCK, 32'h3);
    rd(`OLK_A_LOCK, 32'h0);
    $display("test unlocked done");
  endtask
  task automatic t_modes();
    fuse(32'h103, 32'hFF00_FF00, 1'b0);
    fuse(32'h3, 32'h0, 1'b0);
    rd(`OLK_A_RDATA, 32'h0F00_FF00);
    cons <= 8'h12;
    ro <= 8'h02;
    fuse(32'h103, 32'h0, 1'b1);
    fuse(32'h200, 32'h0, 1'b0);
    for (int i = 0; i < 8; i++) rd(`OLK_A_RDATA, i == 3 ? 32'h0F00_FF00 : '1);
    fuse(32'hF, 32'h0, 1'b0);
    rd(`OLK_A_RDATA, 32'hFFFF_FFFF);
    ro <= 8'h11;
    leg <= 8'h02;
    fuse(32'h1, 32'h0, 1'b1);
    fuse(32'h0, 32'h0, 1'b1);
    fuse(32'h3, 32'h0, 1'b0);
    rd(`OLK_A_RDATA, 32'h0F00_FF00);
    fuse(32'h208, 32'h0, 1'b1);
    fuse(32'h102, 32'h0, 1'b1);
    srd <= 1'b1;
    wr(`OLK_A_DZCMD, 32'h0);
    rd(`OLK_A_STAT, 32'h2);
    wr(`OLK_A_DZCMD, 32'h100);
    rd(`OLK_A_STAT, 32'h3);
    swr <= 1'b1;
    srd <= 1'b0;
    wr(`OLK_A_DZCMD, 32'h100);
    rd(`OLK_A_STAT, 32'h2);
    wr(`OLK_A_DZCMD, 32'h0);
    rd(`OLK_A_STAT, 32'h3);
    $display("test modes done");
  endtask
  task automatic t_key();
    wr(`OLK_A_KEYDAT, 32'h1234_5678);
    wr(`OLK_A_KEYCMD, 32'h41);
    rd(`OLK_A_STAT, 32'hE);
    rd(`OLK_A_KEYDAT, 32'h0);
    wr(`OLK_A_KEYCMD, 32'h1502);
    rd(`OLK_A_STAT, 32'h53E);
    wr(`OLK_A_KEYCMD, 32'h23);
    rd(`OLK_A_STAT, 32'h53E);
    wr(`OLK_A_KEYCMD, 32'h3);
    rd(`OLK_A_STAT, 32'h2, 32'h7);
    wr(`OLK_A_KEYCMD, 32'h1);
    rd(`OLK_A_STAT, 32'h6);
    wr(`OLK_A_KEYCMD, 32'h12);
    rd(`OLK_A_STAT, 32'h3, 32'h7);
    wr(`OLK_A_KEYCMD, 32'h1);
    @(posedge clk_in) pw <= 1'b1;
    @(posedge clk_in) pw <= 1'b0;
    rd(`OLK_A_STAT, 32'h2);
    $display("test key done");
  endtask

  // ==========================================================
  // Run control
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    summarize();
  end

  initial begin
    fails = 0;
    tests_run = 0;
    sys_rst_in <= 1'b1;
    ro <= 8'h01;
    cons <= 8'h02;
    leg <= 8'h03;
    srd <= 1'b0;
    swr <= 1'b0;
    pw <= 1'b0;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_open();
    t_unlocked();
    t_modes();
    t_key();
    summarize();
  end
endmodule
